// >>> shared/adgc_pkg.sv
// Shared constants for the activity detected grant control link
package adgc_pkg;
  // ***************************************************
  // Link field widths
  // ***************************************************
  localparam int GW = 4;                          // Active grants field width
  // ***************************************************
  // Modem register map (byte offsets)
  // ***************************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;     // Enable
  localparam logic [7:0] OFS_TIMEOUT = 8'h04;     // Inactivity timeout, cycles
  localparam logic [7:0] OFS_MAXG    = 8'h08;     // Provisioned max active grants
  localparam logic [7:0] OFS_QLIMIT  = 8'h0c;     // Queue depth limit
  localparam logic [7:0] OFS_STATUS  = 8'h10;     // State, grants, queue depth
  localparam logic [7:0] OFS_INTST   = 8'h14;     // Sticky events, write one clears
  localparam logic [7:0] OFS_INTMSK  = 8'h18;     // Event mask
  // ***************************************************
  // Reset values and field positions
  // ***************************************************
  localparam logic [15:0]   RST_TIMEOUT = 16'h0100;
  localparam logic [GW-1:0] RST_MAXG    = 4'h4;
  localparam logic [7:0]    RST_QLIMIT  = 8'h08;
  localparam logic [7:0]    QIND_LEVEL  = 8'h01;  // Queue indicator above this depth
  localparam int ST_GRANTS = 4;                   // Status: active grants at [7:4]
  localparam int ST_QDEPTH = 8;                   // Status: queue depth at [15:8]
  localparam int EV_START = 0;                    // Activity began
  localparam int EV_STOP  = 1;                    // Zero grant packet sent
  localparam int EV_DROP  = 2;                    // Packet dropped at queue limit
  localparam int NEV      = 3;
  // ***************************************************
  // Flow state and talk spurt burst table
  // ***************************************************
  typedef enum logic [1:0] {ST_POLLED = 2'b00, ST_GRANTED = 2'b01} adgc_state_e;
  localparam int CLK_HZ     = 25_000_000;
  localparam int MS_CYC     = CLK_HZ / 1000;      // Cycles per millisecond
  localparam int QI_PERIOD  = 100;                // 1 % extra grant spacing
  localparam int BURST_10MS = 10;
  localparam int BURST_20MS = 20;
  // Extra grants at a new talk spurt for a grant interval in ms
  function automatic logic [GW-1:0] extra_grants(input int interval_ms);
    if (interval_ms <= BURST_10MS) begin
      return 4'h2;
    end else if (interval_ms <= BURST_20MS) begin
      return 4'h1;
    end
    return 4'h0;
  endfunction : extra_grants
endpackage : adgc_pkg

// >>> shared/adgc_link_if.sv
// Upstream link between the modem end and the headend scheduler
`timescale 1ns/10ps
interface adgc_link_if;
  // Scheduler to modem
  logic                     poll;        // Polled request opportunity
  logic                     grant;       // Unsolicited grant
  // Modem to scheduler
  logic                     req;         // Request sent in a poll
  logic                     pkt;         // Packet sent on a grant
  logic [adgc_pkg::GW-1:0]  pkt_grants;  // Active grants header field
  logic                     pkt_payload; // Packet carries payload
  logic                     queue_ind;   // Queue build-up indicator
  modport modem (input poll, input grant, output req, output pkt, output pkt_grants,
                 output pkt_payload, output queue_ind);
  modport headend (output poll, output grant, input req, input pkt, input pkt_grants,
                   input pkt_payload, input queue_ind);
endinterface : adgc_link_if

// >>> logic/adgc_headend.sv
// Headend scheduler end: polls when idle, grants when active
`timescale 1ns/10ps
module adgc_headend #(
  parameter int POLL_CYC  = 5 * adgc_pkg::MS_CYC,   // Polling interval
  parameter int GRANT_MS  = 10,                     // Grant interval in ms
  parameter int GRANT_CYC = GRANT_MS * adgc_pkg::MS_CYC
) (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Link
  adgc_link_if.headend                 lnk,
  // User side
  output logic                         ugs_mode,
  output logic [adgc_pkg::GW-1:0]      grants_per_int
);
  localparam int CW = $clog2(GRANT_CYC + POLL_CYC + 1);
  localparam logic [CW-1:0] GLAST = CW'(GRANT_CYC - 1);
  localparam logic [CW-1:0] PLAST = CW'(POLL_CYC - 1);
  localparam logic [6:0]    QLAST = 7'(adgc_pkg::QI_PERIOD - 1);

  logic                    ugs_ff;
  logic [adgc_pkg::GW-1:0] ngr_ff;      // Grants per interval
  logic [adgc_pkg::GW-1:0] owe_ff;      // Grants still to issue this interval
  logic [adgc_pkg::GW-1:0] extra_ff;    // Burst grants pending
  logic [CW-1:0]           tick_ff;
  logic [6:0]              qi_ff;       // Grants since last 1 % extra
  logic                    poll_ff;
  logic                    grant_ff;
  logic                    tick_end;
  logic                    more;

  assign tick_end = ugs_ff ? (tick_ff == GLAST) : (tick_ff == PLAST);
  assign more     = (lnk.pkt_grants > ngr_ff);

  // ***************************************************
  // Mode: polling until a request, granting until zero
  // ***************************************************
  // Any arrived packet also resyncs a missed mode change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ugs_ff <= 1'b0;
      ngr_ff <= '0;
    end else if (lnk.pkt && lnk.pkt_grants == '0) begin
      ugs_ff <= 1'b0;
      ngr_ff <= '0;
    end else if (lnk.pkt) begin
      ugs_ff <= 1'b1;
      ngr_ff <= lnk.pkt_grants;
    end else if (lnk.req && !ugs_ff) begin
      ugs_ff <= 1'b1;                    // Request size ignored
      ngr_ff <= adgc_pkg::GW'(1);
    end
  end

  // Interval timer, restarted on a request while polling, not on a zero packet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff <= '0;
    end else if (tick_end || (lnk.req && !ugs_ff)) begin
      tick_ff <= '0;
    end else begin
      tick_ff <= tick_ff + CW'(1);
    end
  end

  // ***************************************************
  // Grant issue: pool of grants, burst at spurt start
  // ***************************************************
  // Burst is loaded on entry to granting and on an increase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extra_ff <= '0;
      owe_ff   <= '0;
      qi_ff    <= '0;
      grant_ff <= 1'b0;
      poll_ff  <= 1'b0;
    end else begin
      grant_ff <= 1'b0;
      poll_ff  <= !ugs_ff && tick_end;
      if ((lnk.req && !ugs_ff) || (lnk.pkt && more)) begin
        extra_ff <= adgc_pkg::extra_grants(GRANT_MS);
      end else if (ugs_ff && owe_ff == '0 && extra_ff != '0) begin
        extra_ff <= extra_ff - adgc_pkg::GW'(1);
        grant_ff <= 1'b1;
      end
      if (!ugs_ff) begin
        owe_ff <= '0;
      end else if (tick_end) begin
        owe_ff <= ngr_ff;
        if (lnk.queue_ind && qi_ff == QLAST) begin
          owe_ff <= ngr_ff + adgc_pkg::GW'(1); // At most 1 % extra
        end
      end else if (owe_ff != '0) begin
        owe_ff   <= owe_ff - adgc_pkg::GW'(1);
        grant_ff <= 1'b1;                // Unbound pool grant
      end
      if (!lnk.queue_ind || (tick_end && qi_ff == QLAST)) begin
        qi_ff <= '0;
      end else if (grant_ff && qi_ff != QLAST) begin
        qi_ff <= qi_ff + 7'(1);
      end
    end
  end

  assign lnk.poll       = poll_ff;
  assign lnk.grant      = grant_ff;
  assign ugs_mode       = ugs_ff;
  assign grants_per_int = ngr_ff;
endmodule : adgc_headend

// >>> logic/adgc_modem.sv
// Modem end: activity detection, grant requests and header field
// Function
// - Every granted packet carries needed grant count
// - Requested count clipped to provisioned maximum
// - Headend polls when idle, grants when active
// - Polled and active: request one grant
// - Several active subflows reported from first packet
// - All idle: one zero packet, then stop
// - Final zero grant packet has no payload
// - Headend stops grants on zero report
// - Headend ignores request size, uses grant size
// - Restart through poll or running grant
// - Needs reported continuously, no acknowledgement
// - Per classifier timer; grants equal active subflows, clipped to the provisioned maximum
// - Headend bursts extra grants at spurt start
// - Extra grants 2, 1, 0 for 10/20/30 ms
// - Grants form a shared pool, no binding
// - Upstream queue depth has an upper limit
// - Queue indicator while packets build up
`timescale 1ns/10ps
module adgc_modem #(
  parameter int NCLS = 4,                 // Classifiers (subflows)
  parameter int TW   = 16                 // Activity timer width
) (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  output logic                        irq,
  // Classifier packet arrivals
  input  wire logic [NCLS-1:0]        cls_pkt,
  // Link
  adgc_link_if.modem                  lnk
);
  // ***************************************************
  // Declarations
  // ***************************************************
  logic                          en_ff;
  logic [TW-1:0]                 tmo_ff;
  logic [adgc_pkg::GW-1:0]       maxg_ff;
  logic [7:0]                    qlim_ff;
  logic [adgc_pkg::NEV-1:0]      ist_ff;
  logic [adgc_pkg::NEV-1:0]      imsk_ff;
  logic                          pready_ff;
  logic [31:0]                   prdata_ff;
  logic                          pslverr_ff;
  logic                          irq_ff;
  logic [TW-1:0]                 tmr_ff [NCLS];
  logic [NCLS-1:0]               act_ff;
  logic [7:0]                    qd_ff;
  adgc_pkg::adgc_state_e         st_ff;
  adgc_pkg::adgc_state_e         nxt_st;
  logic                          req_ff;
  logic                          pkt_ff;
  logic [adgc_pkg::GW-1:0]       pgr_ff;
  logic                          pay_ff;
  logic                          qind_ff;
  logic [adgc_pkg::GW-1:0]       need;
  logic [adgc_pkg::NEV-1:0]      ev;
  logic                          wr;
  logic                          rd;
  logic                          send;
  logic                          send_zero;
  logic                          enq;
  logic                          deq;
  logic [7:0]                    narr;

  // Number of set bits in a classifier vector
  function automatic logic [7:0] count_ones(input logic [NCLS-1:0] v);
    logic [7:0] c;
    c = '0;
    for (int i = 0; i < NCLS; i++) begin
      c = c + 8'(v[i]);
    end
    return c;
  endfunction : count_ones

  // ***************************************************
  // APB register access
  // ***************************************************
  assign wr = psel && penable && pwrite && pready_ff;
  assign rd = psel && !penable && !pwrite;

  // Zero wait state: ready rises for the access cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= 1'b0;
      if (psel && !penable) begin
        prdata_ff  <= '0;
        pslverr_ff <= paddr > adgc_pkg::OFS_INTMSK || paddr[1:0] != 2'b00;
      end
      if (rd) begin
        if (paddr == adgc_pkg::OFS_CTRL) begin
          prdata_ff <= 32'(en_ff);
        end else if (paddr == adgc_pkg::OFS_TIMEOUT) begin
          prdata_ff <= 32'(tmo_ff);
        end else if (paddr == adgc_pkg::OFS_MAXG) begin
          prdata_ff <= 32'(maxg_ff);
        end else if (paddr == adgc_pkg::OFS_QLIMIT) begin
          prdata_ff <= 32'(qlim_ff);
        end else if (paddr == adgc_pkg::OFS_STATUS) begin
          prdata_ff <= 32'({qd_ff, need, 3'h0, st_ff == adgc_pkg::ST_GRANTED});
        end else if (paddr == adgc_pkg::OFS_INTST) begin
          prdata_ff <= 32'(ist_ff);
        end else if (paddr == adgc_pkg::OFS_INTMSK) begin
          prdata_ff <= 32'(imsk_ff);
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff   <= 1'b0;
      tmo_ff  <= TW'(adgc_pkg::RST_TIMEOUT);
      maxg_ff <= adgc_pkg::RST_MAXG;
      qlim_ff <= adgc_pkg::RST_QLIMIT;
      imsk_ff <= '0;
    end else if (wr) begin
      if (paddr == adgc_pkg::OFS_CTRL) begin
        en_ff <= pwdata[0];
      end else if (paddr == adgc_pkg::OFS_TIMEOUT) begin
        tmo_ff <= pwdata[TW-1:0];
      end else if (paddr == adgc_pkg::OFS_MAXG) begin
        maxg_ff <= pwdata[adgc_pkg::GW-1:0];
      end else if (paddr == adgc_pkg::OFS_QLIMIT) begin
        qlim_ff <= pwdata[7:0];
      end else if (paddr == adgc_pkg::OFS_INTMSK) begin
        imsk_ff <= pwdata[adgc_pkg::NEV-1:0];
      end
    end
  end

  // Sticky events; a new event beats a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (wr && paddr == adgc_pkg::OFS_INTST) begin
        ist_ff <= (ist_ff & ~pwdata[adgc_pkg::NEV-1:0]) | ev;
      end else begin
        ist_ff <= ist_ff | ev;
      end
      irq_ff <= |(ist_ff & imsk_ff);
    end
  end

  // ***************************************************
  // Activity detection per classifier
  // ***************************************************
  // Timer reloads on every packet while enabled; expiry marks the subflow idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ff <= '0;
      for (int i = 0; i < NCLS; i++) begin
        tmr_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCLS; i++) begin
        if (cls_pkt[i] && en_ff) begin
          tmr_ff[i] <= tmo_ff;
          act_ff[i] <= 1'b1;             // Active at once
        end else if (tmr_ff[i] != '0) begin
          tmr_ff[i] <= tmr_ff[i] - TW'(1);
        end else begin
          act_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Needed grants: active subflows, clipped to the provisioned maximum
  always_comb begin
    narr = count_ones(act_ff);
    need = (narr > 8'(maxg_ff)) ? maxg_ff : narr[adgc_pkg::GW-1:0];
  end

  // ***************************************************
  // Upstream queue
  // ***************************************************
  // Grants are used by whichever subflow is queued first, no binding
  assign deq = send && qd_ff != '0;
  assign enq = en_ff && (|cls_pkt) && qd_ff < qlim_ff;

  // Depth count; arrivals beyond the limit are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qd_ff <= '0;
    end else if (enq && !deq) begin
      qd_ff <= qd_ff + 8'h01;
    end else if (deq && !enq) begin
      qd_ff <= qd_ff - 8'h01;
    end
  end

  // ***************************************************
  // Flow state and link transmit
  // ***************************************************
  // A grant while active always sends, even when believed polled
  assign send      = lnk.grant && en_ff && need != '0;
  assign send_zero = lnk.grant && st_ff == adgc_pkg::ST_GRANTED && need == '0;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      adgc_pkg::ST_POLLED: begin
        if (send) begin
          nxt_st = adgc_pkg::ST_GRANTED;
        end
      end
      default: begin
        if (send_zero || !en_ff) begin
          nxt_st = adgc_pkg::ST_POLLED;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= adgc_pkg::ST_POLLED;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Packet, header field and request pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff  <= 1'b0;
      pkt_ff  <= 1'b0;
      pgr_ff  <= '0;
      pay_ff  <= 1'b0;
      qind_ff <= 1'b0;
    end else begin
      req_ff  <= lnk.poll && en_ff && need != '0; // One grant asked
      pkt_ff  <= send || send_zero;      // Single zero packet
      pay_ff  <= deq;                    // Zero packet empty
      qind_ff <= qd_ff > adgc_pkg::QIND_LEVEL;
      if (send || send_zero) begin
        pgr_ff <= need;
      end
    end
  end

  assign ev[adgc_pkg::EV_START] = send && st_ff == adgc_pkg::ST_POLLED;
  assign ev[adgc_pkg::EV_STOP]  = send_zero;
  assign ev[adgc_pkg::EV_DROP]  = en_ff && (|cls_pkt) && !enq;

  assign lnk.req         = req_ff;
  assign lnk.pkt         = pkt_ff;
  assign lnk.pkt_grants  = pgr_ff;
  assign lnk.pkt_payload = pay_ff;
  assign lnk.queue_ind   = qind_ff;
  assign pready          = pready_ff;
  assign prdata          = prdata_ff;
  assign pslverr         = pslverr_ff;
  assign irq             = irq_ff;
endmodule : adgc_modem

// >>> test/adgc_checker.sv
// Concurrent checks on the link between the modem end and the headend end
`timescale 1ns/10ps
module adgc_checker #(
  parameter int MAXG_LIM = 2                      // Grant ceiling the bench programs
) (
  // Clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // Headend to modem
  input wire logic                    poll,
  input wire logic                    grant,
  // Modem to headend
  input wire logic                    req,
  input wire logic                    pkt,
  input wire logic [adgc_pkg::GW-1:0] pkt_grants,
  input wire logic                    pkt_payload,
  input wire logic                    queue_ind
);
  // ***************************************************
  // Helper state
  // ***************************************************
  logic zero_sent_ff;

  // A zero packet is remembered until a request or a nonzero packet restarts the flow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_sent_ff <= 1'b0;
    end else if (req || (pkt && pkt_grants != '0)) begin
      zero_sent_ff <= 1'b0;
    end else if (pkt) begin
      zero_sent_ff <= 1'b1;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ***************************************************
  // Assertions
  // ***************************************************
  // Packets only answer grants, one cycle later
  chk_pkt_after_grant: assert property (pkt |-> $past(grant))
    else $error("packet without a grant one cycle before");
  chk_req_after_poll: assert property (req |-> $past(poll))
    else $error("request without a poll one cycle before");
  chk_zero_no_payload: assert property (pkt && pkt_grants == '0 |-> !pkt_payload)
    else $error("zero grant packet carries payload");
  // A second zero packet in a row means the modem did not stop
  chk_single_zero: assert property (pkt && pkt_grants == '0 |-> !zero_sent_ff)
    else $error("more than one zero grant packet");
  chk_grant_limit: assert property (pkt |-> pkt_grants <= MAXG_LIM)
    else $error("requested grants above provisioned maximum");
  chk_poll_grant_excl: assert property (!(poll && grant))
    else $error("poll and grant in the same cycle");
  // Two cycles allow a grant already launched before the zero report landed
  chk_stop_after_zero: assert property (pkt && pkt_grants == '0 |-> ##2 !grant [*8])
    else $error("grants continue after zero report");
  // A 10 ms interval earns two extra grants back to back once granting resumes
  chk_burst_after_req: assert property (req |-> ##[1:100] grant [*2])
    else $error("no grant burst after polled request");

  // Main scenarios reached
  cov_restart_req: cover property (req);
  cov_zero_pkt: cover property (pkt && pkt_grants == '0);
  cov_two_grants: cover property (pkt && pkt_grants == 4'h2);
  cov_queue_ind: cover property ($rose(queue_ind));
endmodule : adgc_checker

// >>> test/activity_detected_grant_control_test.sv
// Self-checking bench joining the modem end and the headend end over the link
`timescale 1ns/10ps
module activity_detected_grant_control_test;
  // ***************************************************
  // Bench state
  // ***************************************************
  localparam int MAXG_SET = 2;                    // Below the three subflows used later
  logic                    pclk        = 1'b0;
  logic                    presetn     = 1'b0;
  logic                    psel        = 1'b0;
  logic                    penable     = 1'b0;
  logic                    pwrite      = 1'b0;
  logic [7:0]              paddr       = 8'h00;
  logic [31:0]             pwdata      = 32'h0;
  logic                    pready;
  logic [31:0]             prdata;
  logic                    pslverr;
  logic                    irq;
  logic [3:0]              cls_pkt     = 4'h0;
  logic [3:0]              active_mask = 4'h0;
  logic                    ugs_mode;
  logic [adgc_pkg::GW-1:0] grants_per_int;
  logic [adgc_pkg::GW-1:0] last_g;
  logic                    last_pay;
  logic [31:0]             rd;
  logic                    err;
  int                      fails       = 0;
  int                      checked     = 0;
  int                      cycles      = 0;
  int                      pkt_cnt     = 0;
  int                      snap;
  logic [7:0]              ofs_tab [5] = '{adgc_pkg::OFS_CTRL, adgc_pkg::OFS_TIMEOUT, adgc_pkg::OFS_MAXG,
                                           adgc_pkg::OFS_QLIMIT, adgc_pkg::OFS_INTMSK};
  logic [31:0]             rst_tab [5] = '{32'h0, {16'h0, adgc_pkg::RST_TIMEOUT}, {28'h0, adgc_pkg::RST_MAXG},
                                           {24'h0, adgc_pkg::RST_QLIMIT}, 32'h0};

  always #20 pclk = ~pclk;

  // ***************************************************
  // Design, link and checker
  // ***************************************************
  adgc_link_if lnk_if ();
  adgc_modem #(.NCLS(4), .TW(16)) adgc_modem_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq), .cls_pkt(cls_pkt),
    .lnk(lnk_if));
  // Short poll and grant spacing keep the run brief; 10 ms interval selects a burst of two
  adgc_headend #(.POLL_CYC(20), .GRANT_MS(10), .GRANT_CYC(40)) adgc_headend_inst (
    .pclk(pclk), .presetn(presetn), .lnk(lnk_if), .ugs_mode(ugs_mode), .grants_per_int(grants_per_int));
  adgc_checker #(.MAXG_LIM(MAXG_SET)) adgc_checker_inst (
    .pclk(pclk), .presetn(presetn), .poll(lnk_if.poll), .grant(lnk_if.grant), .req(lnk_if.req),
    .pkt(lnk_if.pkt), .pkt_grants(lnk_if.pkt_grants), .pkt_payload(lnk_if.pkt_payload),
    .queue_ind(lnk_if.queue_ind));

  // Arrivals every fifth cycle keep chosen subflows alive and outpace the grants
  always @(posedge pclk) begin
    cls_pkt <= (cycles % 5 == 0) ? active_mask : 4'h0;
  end

  // Cycle count, packet count and the hang limit
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (lnk_if.pkt === 1'b1) begin
      pkt_cnt <= pkt_cnt + 1;
    end
    if (cycles == 20000) begin
      fails = fails + 1;
      finish_test();
    end
  end

  // ***************************************************
  // Tasks
  // ***************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen high at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, n < 50}, 32'h1);
  endtask : apb

  // Kind 0 waits for a request, 1 for any packet, 2 for a zero grant packet
  task automatic wait_link(input int kind);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (!((kind == 0 && lnk_if.req === 1'b1) || (kind != 0 && lnk_if.pkt === 1'b1 &&
               (kind == 1 || lnk_if.pkt_grants === 4'h0))) && n < 500);
    last_g   = lnk_if.pkt_grants;
    last_pay = lnk_if.pkt_payload;
    chk({31'h0, n < 500}, 32'h1);
  endtask : wait_link

  task automatic finish_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // ***************************************************
  // Scenarios
  // ***************************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then a refused unmapped read
    for (int i = 0; i < 5; i++) begin
      apb(ofs_tab[i], 1'b0, 32'h0);
      chk(rd, rst_tab[i]);
    end
    apb(8'h1c, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Short timeout, tight queue, start event unmasked
    apb(adgc_pkg::OFS_TIMEOUT, 1'b1, 32'h0000000a);
    apb(adgc_pkg::OFS_MAXG, 1'b1, 32'h00000002);
    apb(adgc_pkg::OFS_QLIMIT, 1'b1, 32'h00000002);
    apb(adgc_pkg::OFS_INTMSK, 1'b1, 32'h00000001);
    apb(adgc_pkg::OFS_CTRL, 1'b1, 32'h00000001);
    // One subflow wakes: request in a poll, then one grant with payload
    active_mask <= 4'h1;
    wait_link(0);
    wait_link(1);
    chk({27'h0, last_pay, last_g}, 32'h00000011);
    repeat (3) @(posedge pclk);
    chk({27'h0, ugs_mode, grants_per_int}, 32'h00000011);
    // Start interrupt raised, then cleared by writing one
    chk({31'h0, irq}, 32'h1);
    apb(adgc_pkg::OFS_INTST, 1'b1, 32'h00000001);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    // All quiet: one empty zero packet, then silence and a return to polling
    active_mask <= 4'h0;
    wait_link(2);
    chk({31'h0, last_pay}, 32'h0);
    repeat (2) @(posedge pclk);
    snap = pkt_cnt;
    repeat (100) @(posedge pclk);
    chk(32'(pkt_cnt), 32'(snap));
    chk({31'h0, ugs_mode}, 32'h0);
    apb(adgc_pkg::OFS_INTST, 1'b0, 32'h0);
    chk(rd & 32'h2, 32'h2);
    // Three subflows restart together: first packet already clipped to the ceiling
    active_mask <= 4'h7;
    wait_link(0);
    wait_link(1);
    chk({28'h0, last_g}, 32'h2);
    // Arrivals outrun grants: indicator rises, queue stays capped, drops recorded
    snap = 0;
    while (lnk_if.queue_ind !== 1'b1 && snap < 300) begin
      @(posedge pclk);
      snap++;
    end
    chk({31'h0, snap < 300}, 32'h1);
    apb(adgc_pkg::OFS_INTST, 1'b0, 32'h0);
    chk(rd & 32'h4, 32'h4);
    apb(adgc_pkg::OFS_STATUS, 1'b0, 32'h0);
    chk({31'h0, rd[15:8] > 8'h02}, 32'h0);
    finish_test();
  end
endmodule : activity_detected_grant_control_test
